// ===== design/pssc_pkg.sv
/*
 * Package for the processor sleep state control block: power states,
 * clock gate groups and the port bundles shared by the design files.
 * Assumes a single bus clock domain with synchronous active-high reset.
 */
package pssc_pkg;

    // Power states of the core
    typedef enum logic [1:0] {
        PSSC_RUN,
        PSSC_GRANT_WAIT,
        PSSC_STOP_GRANT,
        PSSC_SLEEP
    } pssc_state_t;

    // Synchroniser depth for pin inputs
    localparam int PSSC_SYNC_DEPTH = 3;

    // Reset level of an active-low request pin (deasserted)
    localparam logic PSSC_PIN_IDLE = 1'h1;

    // Internal clock enables, one per unit group
    typedef struct packed {
        logic pll;
        logic bus;
        logic apic;
        logic core;
    } pssc_clk_en_t;

    localparam pssc_clk_en_t PSSC_CLK_ALL = '{pll: 1'h1, bus: 1'h1, apic: 1'h1, core: 1'h1};
    localparam pssc_clk_en_t PSSC_CLK_GRANT = '{pll: 1'h1, bus: 1'h1, apic: 1'h1, core: 1'h0};
    localparam pssc_clk_en_t PSSC_CLK_SLEEP = '{pll: 1'h1, bus: 1'h0, apic: 1'h0, core: 1'h0};

    // Event inputs from the rest of the core
    typedef struct packed {
        logic snoop;
        logic intr;
    } pssc_evt_t;

endpackage

// ===== design/pssc_sync.sv
/*
 * Three-stage synchroniser with agreement filter for one pin input.
 * Assumes the pin is asynchronous to clk; reset loads the idle level.
 */
`timescale 1ns/10ps
`default_nettype none

module pssc_sync (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Pin and filtered level
    input wire logic pinIn,
    output logic level
);

    logic [pssc_pkg::PSSC_SYNC_DEPTH-1:0] stage_r;

    always_ff @(posedge clk) begin
        if (rst) begin
            stage_r <= {pssc_pkg::PSSC_SYNC_DEPTH{pssc_pkg::PSSC_PIN_IDLE}};
        end else begin
            stage_r <= {stage_r[pssc_pkg::PSSC_SYNC_DEPTH-2:0], pinIn};
        end
    end

    // Change counts once stages two and three agree
    always_ff @(posedge clk) begin
        if (rst) begin
            level <= pssc_pkg::PSSC_PIN_IDLE;
        end else if (stage_r[1] == stage_r[2]) begin
            level <= stage_r[2];
        end
    end

endmodule // pssc_sync

`default_nettype wire

// ===== design/pssc_ctrl.sv
/*
 * Processor sleep state control: running, Stop-Grant and Sleep states,
 * internal clock gating, acknowledge issue and snoop/interrupt gating.
 * Assumes request pins are asynchronous and active low, and that the
 * bus unit reports completion of the acknowledge transaction.
 */
`timescale 1ns/10ps
`default_nettype none

module pssc_ctrl (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Request pins, active low, asynchronous
    input wire logic stop_clock_request_n,
    input wire logic sleep_request_n,
    // Events from the core
    input wire pssc_pkg::pssc_evt_t evtIn,
    // Acknowledge transaction handshake with the bus unit
    output logic ackReq,
    input wire logic ackDone,
    // Clock gates and state
    output pssc_pkg::pssc_clk_en_t clkEn,
    output pssc_pkg::pssc_state_t state,
    // Gated events and interrupt service
    output logic snoopEn,
    output logic intrPending,
    output logic intrService
);

    logic stopReq;
    logic stopLvl;
    logic sleepLvl;
    pssc_pkg::pssc_state_t state_r;
    pssc_pkg::pssc_state_t state_nxt;
    logic intrPend_r;
    logic ackReq_r;
    pssc_pkg::pssc_clk_en_t clkEn_r;
    pssc_pkg::pssc_clk_en_t clkEn_nxt;
    logic service_r;
    logic service_nxt;
    logic sleepReq;
    logic inRun;
    logic inGrantWait;
    logic inSleep;
    logic ackTaken;
    logic ackReq_nxt;
    logic snoopEn_r;
    logic snoopEn_nxt;
    logic intrAccept;
    logic intrClear;
    logic intrPend_nxt;

    // Stop-clock pin
    pssc_sync stopSync (
        .clk(clk),
        .rst(rst),
        .pinIn(stop_clock_request_n),
        .level(stopLvl)
    );

    // Sleep pin
    pssc_sync sleepSync (
        .clk(clk),
        .rst(rst),
        .pinIn(sleep_request_n),
        .level(sleepLvl)
    );

    // Requests are active low at the pins
    assign stopReq = !stopLvl;
    assign sleepReq = !sleepLvl;

    // State decode
    assign inRun = state_r == pssc_pkg::PSSC_RUN;
    assign inGrantWait = state_r == pssc_pkg::PSSC_GRANT_WAIT;
    assign inSleep = state_r == pssc_pkg::PSSC_SLEEP;

    // Completion only counts while the acknowledge is outstanding
    assign ackTaken = ackDone && inGrantWait;

    // State transitions
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            pssc_pkg::PSSC_RUN: begin
                // Stop-clock request starts the acknowledge
                if (stopReq) begin
                    state_nxt = pssc_pkg::PSSC_GRANT_WAIT;
                end
            end
            pssc_pkg::PSSC_GRANT_WAIT: begin
                if (ackTaken) begin
                    state_nxt = pssc_pkg::PSSC_STOP_GRANT;
                end
            end
            pssc_pkg::PSSC_STOP_GRANT: begin
                // Sleep outranks a stop-clock release
                if (sleepReq) begin
                    state_nxt = pssc_pkg::PSSC_SLEEP;
                end else if (!stopReq) begin
                    state_nxt = pssc_pkg::PSSC_RUN;
                end
            end
            pssc_pkg::PSSC_SLEEP: begin
                // Stop-clock release waits for sleep release
                if (!sleepReq) begin
                    state_nxt = pssc_pkg::PSSC_STOP_GRANT;
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_r <= pssc_pkg::PSSC_RUN;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Acknowledge request held until the bus unit completes it
    always_comb begin
        ackReq_nxt = 1'h0;
        if (state_nxt == pssc_pkg::PSSC_GRANT_WAIT) begin
            ackReq_nxt = 1'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ackReq_r <= 1'h0;
        end else begin
            ackReq_r <= ackReq_nxt;
        end
    end

    // Clock gates follow the next state
    always_comb begin
        unique case (state_nxt)
            pssc_pkg::PSSC_SLEEP: clkEn_nxt = pssc_pkg::PSSC_CLK_SLEEP;
            pssc_pkg::PSSC_STOP_GRANT: clkEn_nxt = pssc_pkg::PSSC_CLK_GRANT;
            pssc_pkg::PSSC_GRANT_WAIT: clkEn_nxt = pssc_pkg::PSSC_CLK_ALL;
            pssc_pkg::PSSC_RUN: clkEn_nxt = pssc_pkg::PSSC_CLK_ALL;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            clkEn_r <= pssc_pkg::PSSC_CLK_ALL;
        end else begin
            clkEn_r <= clkEn_nxt;
        end
    end

    // Interrupt latch; ignored in Sleep, set wins over service
    assign intrAccept = evtIn.intr && !inSleep;
    assign intrClear = inRun;

    always_comb begin
        intrPend_nxt = intrPend_r;
        if (intrAccept) begin
            intrPend_nxt = 1'h1;
        end else if (intrClear) begin
            intrPend_nxt = 1'h0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            intrPend_r <= 1'h0;
        end else begin
            intrPend_r <= intrPend_nxt;
        end
    end

    // One-cycle service pulse once running
    assign service_nxt = intrPend_r && inRun;

    always_ff @(posedge clk) begin
        if (rst) begin
            service_r <= 1'h0;
        end else begin
            service_r <= service_nxt;
        end
    end

    // Snoop gate registered alongside the state
    always_comb begin
        snoopEn_nxt = 1'h1;
        if (state_nxt == pssc_pkg::PSSC_SLEEP) begin
            snoopEn_nxt = 1'h0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            snoopEn_r <= 1'h1;
        end else begin
            snoopEn_r <= snoopEn_nxt;
        end
    end

    assign state = state_r;
    assign ackReq = ackReq_r;
    assign clkEn = clkEn_r;
    assign snoopEn = snoopEn_r;
    assign intrPending = intrPend_r;
    assign intrService = service_r;

endmodule // pssc_ctrl

`default_nettype wire

// ===== tb/pssc_sys_pm.sv
/* Bus unit model: one-cycle ackDone after lag cycles of ackReq. Assumes pssc_ctrl. */
`timescale 1ns/10ps
`default_nettype none
module pssc_sys_pm (
    // Clock and acknowledge handshake
    input wire logic clk,
    input wire logic ackReq,
    output logic ackDone
);
    int lag = 0;
    int cnt = 0;
    // Prompt or slow completion, one driver for ackDone
    initial begin
        ackDone = 1'h0;
        forever begin
            @(posedge clk);
            ackDone <= #1 ackReq && !ackDone && cnt >= lag;
            cnt <= ackReq ? cnt + 1 : 0;
        end
    end
endmodule // pssc_sys_pm
`default_nettype wire

// ===== tb/pssc_ctrl_chk.sv
/* Port checks of pssc_ctrl, bound below. Assumes one clock, sync reset. */
`timescale 1ns/10ps
`default_nettype none
module pssc_ctrl_chk (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Watched outputs
    input wire logic ackReq,
    input wire logic snoopEn,
    input wire pssc_pkg::pssc_clk_en_t clkEn,
    input wire pssc_pkg::pssc_state_t state
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    chk_sleep_in: assert property (state == 2'h3 |-> $past(state) > 2'h1) else $error("in");
    chk_sleep_clk: assert property (state == 2'h3 |-> clkEn == 4'h8) else $error("clk");
    chk_sleep_deaf: assert property (state == 2'h3 |-> !snoopEn) else $error("snp");
    chk_sleep_out: assert property ($past(state) == 2'h3 |-> state > 2'h1) else $error("out");
    chk_sg_clk: assert property (state == 2'h2 |-> clkEn == 4'hE && snoopEn) else $error("sg");
    chk_ack_up: assert property ($rose(ackReq) |-> state == 2'h1) else $error("up");
    chk_ack_dn: assert property ($fell(ackReq) |-> state == 2'h2) else $error("dn");
    chk_run_clk: assert property (state == 2'h0 |-> clkEn == 4'hF) else $error("run");
endmodule // pssc_ctrl_chk
bind pssc_ctrl pssc_ctrl_chk pssc_ctrl_chk_inst (.clk(clk), .rst(rst), .ackReq(ackReq),
    .snoopEn(snoopEn), .clkEn(clkEn), .state(state));
`default_nettype wire

// ===== tb/pssc_ctrl_tb_top.sv
/* Bench for pssc_ctrl; drives the pins itself. Assumes the bus unit model. */
`timescale 1ns/10ps
`default_nettype none
module pssc_ctrl_tb_top;
    logic clk = 1'h0, rst = 1'h1, stN = 1'h1, slN = 1'h1;
    logic ackReq, ackDone, snoopEn, pend, srv;
    pssc_pkg::pssc_evt_t evtIn = 2'h0;
    pssc_pkg::pssc_clk_en_t clkEn;
    pssc_pkg::pssc_state_t state;
    int n_mismatch = 0, num_checks = 0;
    initial forever #4 clk = ~clk;
    pssc_ctrl pssc_ctrl_inst (.clk(clk), .rst(rst), .stop_clock_request_n(stN),
        .sleep_request_n(slN), .evtIn(evtIn), .ackReq(ackReq), .ackDone(ackDone),
        .clkEn(clkEn), .state(state), .snoopEn(snoopEn), .intrPending(pend),
        .intrService(srv));
    pssc_sys_pm pssc_sys_pm_inst (.clk(clk), .ackReq(ackReq), .ackDone(ackDone));
    task automatic chk(string nm, logic [3:0] seen, logic [3:0] exp);
        num_checks++;
        if (seen !== exp) $display("unexpected %s exp %h seen %h", nm, exp, seen);
        n_mismatch += int'(seen !== exp);
    endtask
    task automatic pin(logic s, logic p, int n);
        stN = s;
        slN = p;
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic t_grant(int lag);
        pssc_sys_pm_inst.lag = lag;
        pin(1'h1, 1'h0, 6);
        chk("st", 4'(state), 4'h0);
        pin(1'h0, 1'h1, 5);
        chk("ack", 4'(ackReq), 4'h1);
        pin(1'h0, 1'h1, lag + 4);
        chk("clk", clkEn, 4'hE);
        chk("ackoff", 4'(ackReq), 4'h0);
        chk("st", 4'(state), 4'h2);
        chk("snp", 4'(snoopEn), 4'h1);
    endtask
    task automatic t_sleep();
        pin(1'h0, 1'h0, 5);
        chk("clk", clkEn, 4'h8);
        chk("snp", 4'(snoopEn), 4'h0);
        evtIn = 2'h3;
        pin(1'h1, 1'h0, 6);
        chk("st", 4'(state), 4'h3);
        chk("pnd", 4'(pend), 4'h0);
        pin(1'h0, 1'h1, 6);
        chk("clk", clkEn, 4'hE);
        chk("snp", 4'(snoopEn), 4'h1);
        chk("pnd", 4'(pend), 4'h1);
        evtIn = 2'h0;
        pin(1'h1, 1'h1, 5);
        chk("clk", clkEn, 4'hF);
        chk("srv", 4'(srv), 4'h0);
        pin(1'h1, 1'h1, 1);
        chk("srv", 4'(srv), 4'h1);
        chk("pnd", 4'(pend), 4'h0);
    endtask
    task automatic t_reset();
        pin(1'h0, 1'h0, 5);
        chk("st", 4'(state), 4'h3);
        rst = 1'h1;
        pin(1'h1, 1'h1, 4);
        chk("st", 4'(state), 4'h0);
        chk("clk", clkEn, 4'hF);
        chk("snp", 4'(snoopEn), 4'h1);
        rst = 1'h0;
        pin(1'h1, 1'h1, 2);
        chk("st", 4'(state), 4'h0);
        chk("ack", 4'(ackReq), 4'h0);
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        pin(1'h1, 1'h1, 12);
        rst = 1'h0;
        t_grant(0);
        t_sleep();
        t_grant(7);
        t_sleep();
        t_grant(0);
        t_reset();
        give_verdict();
    end
    initial begin
        #3200;
        n_mismatch++;
        give_verdict();
    end
endmodule // pssc_ctrl_tb_top
`default_nettype wire
